//--- hdl/psrc_lf_timer.sv
// Down counter advanced by low-frequency ticks, with load and expiry pulse
module psrc_lf_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // Control
  input  wire logic             run,
  input  wire logic             tick,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  // Status
  output logic      [WIDTH-1:0] count,
  output logic                  expire
);

  logic [WIDTH-1:0] next_count;
  logic             next_expire;

  // Load wins over counting so a clear never loses to a tick
  always_comb begin
    next_count  = count;
    next_expire = 1'b0;
    if (load) begin
      next_count = load_val;
    end else if (run && tick) begin
      if (count == {{(WIDTH-1){1'b0}}, 1'b1} || count == '0) begin
        next_expire = 1'b1;
        next_count  = load_val;
      end else begin
        next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count  <= '0;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      expire <= next_expire;
    end
  end

endmodule

//--- hdl/psrc_pkg.sv
// Constants and types shared by the power-state and reset controller
package psrc_pkg;

  // ************************************************************
  // Clocking and timing
  // ************************************************************
  localparam int MCLK_HZ       = 125_000_000;
  localparam int MCLK_MHZ      = MCLK_HZ / 1_000_000;
  // Least hold of the core reset after the last cause goes away
  localparam int RST_HOLD_NS   = 1000;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS * MCLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W     = $clog2(RST_HOLD_CYC + 1);
  // Cycles spent waking the core once its clock runs again
  localparam int WAKE_CYC      = 16;
  localparam int WAKE_CNT_W    = $clog2(WAKE_CYC);

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int SLEEP_TMR_W   = 32;
  localparam int WDT_W         = 16;
  localparam int WAKE_LINES    = 8;
  localparam int DIV_SEL_W     = 2;
  localparam int DIV_CNT_W     = 3;

  // ************************************************************
  // Reset cause field positions
  // ************************************************************
  localparam int NUM_CAUSES    = 4;
  localparam int CAUSE_PIN     = 0;
  localparam int CAUSE_POR     = 1;
  localparam int CAUSE_BOD     = 2;
  localparam int CAUSE_WDT     = 3;
  localparam logic [NUM_CAUSES-1:0] CAUSE_RST = 4'h0;

  // ************************************************************
  // Power states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_RADIO,
    ST_IDLE,
    ST_SLEEP,
    ST_DEEP,
    ST_WAKE
  } psrc_state_t;

endpackage

//--- hdl/psrc_top.sv
// Power-state sequencing and reset generation for the core and its clocks
module psrc_top
  import psrc_pkg::*;
#(
  parameter int SLEEP_W = SLEEP_TMR_W,
  parameter int WDOG_W  = WDT_W
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  // Reset sources
  input  wire logic                  ext_reset_pin_n,
  input  wire logic                  por_n,
  input  wire logic                  brownout,
  // Core handshake
  input  wire logic                  wait_for_interrupt_instr,
  input  wire logic                  deep_sleep_sel,
  input  wire logic                  idle_req,
  input  wire logic                  radio_req,
  output logic                       core_reset_n,
  output logic                       core_run,
  output logic                       core_clk_en,
  output logic                       wake_irq,
  output logic                       wake_by_timer,
  output logic [NUM_CAUSES-1:0]      rst_cause,
  output psrc_state_t                power_state,
  // Wake lines
  input  wire logic [WAKE_LINES-1:0] wake_port0_lines,
  input  wire logic [WAKE_LINES-1:0] wake_port1_lines,
  input  wire logic [WAKE_LINES-1:0] wake_port0_en,
  input  wire logic [WAKE_LINES-1:0] wake_port1_en,
  // Low-frequency clock
  input  wire logic                  lf_tick,
  input  wire logic                  lf_rc_sel,
  output logic                       lf_xtal_en,
  output logic                       lf_rc_en,
  // Sleep timer
  input  wire logic [SLEEP_W-1:0]    sleep_interval,
  output logic                       sleep_timer_en,
  // Watchdog
  input  wire logic                  wdt_enable,
  input  wire logic                  wdt_interval_mode,
  input  wire logic                  wdt_clear,
  input  wire logic [WDOG_W-1:0]     wdt_reload,
  output logic                       wdt_irq,
  // Supplies and high-frequency clock
  input  wire logic                  hf_xtal_is_16m,
  input  wire logic [DIV_SEL_W-1:0]  sys_clk_div_sel,
  output logic                       dig_reg_en,
  output logic                       hf_xtal_en,
  output logic                       hf_doubler_en,
  output logic                       sys_clk_div_tick
);

  // ************************************************************
  // Declarations
  // ************************************************************
  psrc_state_t             state;
  psrc_state_t             next_state;
  logic [RST_CNT_W-1:0]    rst_cnt;
  logic [RST_CNT_W-1:0]    next_rst_cnt;
  logic [WAKE_CNT_W-1:0]   wake_cnt;
  logic [WAKE_CNT_W-1:0]   next_wake_cnt;
  logic                    in_reset;
  logic                    next_in_reset;
  logic                    next_core_reset_n;
  logic [NUM_CAUSES-1:0]   next_rst_cause;
  logic                    next_wake_irq;
  logic                    next_wake_by_timer;
  logic                    next_lf_xtal_en;
  logic                    next_lf_rc_en;
  logic                    next_sleep_timer_en;
  logic                    next_wdt_irq;
  logic                    next_dig_reg_en;
  logic                    next_hf_xtal_en;
  logic                    next_hf_doubler_en;
  logic [DIV_CNT_W-1:0]    div_cnt;
  logic [DIV_CNT_W-1:0]    next_div_cnt;
  logic [DIV_CNT_W-1:0]    div_mask;
  logic [NUM_CAUSES-1:0]   cause_now;
  logic                    chip_rst_req;
  logic                    run_state;
  logic                    sleep_entry;
  logic                    ext_wake;
  logic                    lf_on;
  logic                    sleep_expire;
  logic                    wdt_expire;

  // ************************************************************
  // Reset causes
  // ************************************************************
  always_comb begin
    cause_now            = CAUSE_RST;
    cause_now[CAUSE_PIN] = !ext_reset_pin_n;
    cause_now[CAUSE_POR] = !por_n;
    cause_now[CAUSE_BOD] = brownout;
    cause_now[CAUSE_WDT] = wdt_expire && !wdt_interval_mode;
  end

  assign chip_rst_req = |cause_now;

  // ************************************************************
  // Wake sources and sleep entry
  // ************************************************************
  // Other port lines never reach this block, so they cannot wake
  assign ext_wake = |(wake_port0_lines & wake_port0_en) |
                    |(wake_port1_lines & wake_port1_en);

  assign run_state = (state == ST_ACTIVE) || (state == ST_RADIO) ||
                     (state == ST_IDLE);

  assign sleep_entry = run_state && core_reset_n && !chip_rst_req &&
                       wait_for_interrupt_instr;

  // ************************************************************
  // Power-state sequencer
  // ************************************************************
  always_comb begin
    next_state         = state;
    next_rst_cnt       = rst_cnt;
    next_wake_cnt      = wake_cnt;
    next_in_reset      = in_reset;
    next_core_reset_n  = core_reset_n;
    next_rst_cause     = rst_cause;
    next_wake_irq      = 1'b0;
    next_wake_by_timer = wake_by_timer;
    if (chip_rst_req) begin
      next_state        = ST_ACTIVE;
      next_rst_cnt      = RST_CNT_W'(RST_HOLD_CYC);
      next_core_reset_n = 1'b0;
      next_in_reset     = 1'b1;
      // Causes seen during one reset episode accumulate
      next_rst_cause    = in_reset ? (rst_cause | cause_now)
                                   : cause_now;
      next_wake_cnt     = '0;
    end else if (rst_cnt != '0) begin
      next_rst_cnt = rst_cnt - RST_CNT_W'(1);
    end else if (!core_reset_n) begin
      next_core_reset_n = 1'b1;
      next_in_reset     = 1'b0;
    end else begin
      case (state)
        ST_ACTIVE, ST_RADIO, ST_IDLE: begin
          if (wait_for_interrupt_instr) begin
            next_state = deep_sleep_sel ? ST_DEEP : ST_SLEEP;
          end else if (radio_req) begin
            next_state = ST_RADIO;
          end else if (idle_req) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_ACTIVE;
          end
        end
        ST_SLEEP: begin
          if (ext_wake || sleep_expire) begin
            next_state         = ST_WAKE;
            next_wake_cnt      = WAKE_CNT_W'(WAKE_CYC - 1);
            next_wake_by_timer = !ext_wake;
          end
        end
        ST_DEEP: begin
          // Timer is unpowered here; only a wake line counts
          if (ext_wake) begin
            next_state         = ST_WAKE;
            next_wake_cnt      = WAKE_CNT_W'(WAKE_CYC - 1);
            next_wake_by_timer = 1'b0;
          end
        end
        ST_WAKE: begin
          if (wake_cnt == '0) begin
            next_state    = ST_ACTIVE;
            next_wake_irq = 1'b1;
          end else begin
            next_wake_cnt = wake_cnt - WAKE_CNT_W'(1);
          end
        end
        default: begin
          next_state = ST_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state         <= ST_ACTIVE;
      rst_cnt       <= '0;
      wake_cnt      <= '0;
      in_reset      <= 1'b0;
      core_reset_n  <= 1'b0;
      rst_cause     <= CAUSE_RST;
      wake_irq      <= 1'b0;
      wake_by_timer <= 1'b0;
    end else begin
      state         <= next_state;
      rst_cnt       <= next_rst_cnt;
      wake_cnt      <= next_wake_cnt;
      in_reset      <= next_in_reset;
      core_reset_n  <= next_core_reset_n;
      rst_cause     <= next_rst_cause;
      wake_irq      <= next_wake_irq;
      wake_by_timer <= next_wake_by_timer;
    end
  end

  assign power_state = state;
  assign core_run    = core_reset_n && run_state;

  // Combinational so the clock stops in the very cycle of the request
  assign core_clk_en = (run_state && !sleep_entry) ||
                       (state == ST_WAKE);

  // ************************************************************
  // Supply and oscillator enables
  // ************************************************************
  assign lf_on = (state != ST_DEEP);

  always_comb begin
    next_dig_reg_en     = !((next_state == ST_SLEEP) ||
                            (next_state == ST_DEEP));
    next_sleep_timer_en = (next_state != ST_DEEP);
    next_lf_xtal_en     = (next_state != ST_DEEP) && !lf_rc_sel;
    next_lf_rc_en       = (next_state != ST_DEEP) && lf_rc_sel;
    next_hf_xtal_en     = next_dig_reg_en;
    next_hf_doubler_en  = hf_xtal_is_16m;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dig_reg_en     <= 1'b1;
      sleep_timer_en <= 1'b1;
      lf_xtal_en     <= 1'b0;
      lf_rc_en       <= 1'b0;
      hf_xtal_en     <= 1'b1;
      hf_doubler_en  <= 1'b0;
    end else begin
      dig_reg_en     <= next_dig_reg_en;
      sleep_timer_en <= next_sleep_timer_en;
      lf_xtal_en     <= next_lf_xtal_en;
      lf_rc_en       <= next_lf_rc_en;
      hf_xtal_en     <= next_hf_xtal_en;
      hf_doubler_en  <= next_hf_doubler_en;
    end
  end

  // ************************************************************
  // System clock divider
  // ************************************************************
  always_comb begin
    div_mask     = DIV_CNT_W'((1 << sys_clk_div_sel) - 1);
    next_div_cnt = div_cnt + DIV_CNT_W'(1);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Divide by 1, 2, 4 or 8 of the full-rate system clock
  assign sys_clk_div_tick = ((div_cnt & div_mask) == '0);

  // ************************************************************
  // Sleep timer and watchdog
  // ************************************************************
  // Interval is taken when the core asks for light sleep
  psrc_lf_timer #(
    .WIDTH    (SLEEP_W)
  ) u_sleep_timer (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .run      (state == ST_SLEEP),
    .tick     (lf_tick),
    .load     (sleep_entry && !deep_sleep_sel),
    .load_val (sleep_interval),
    .count    (),
    .expire   (sleep_expire)
  );

  // Stops with the 32 kHz clock in deep sleep, so it cannot bite there
  psrc_lf_timer #(
    .WIDTH    (WDOG_W)
  ) u_watchdog_counter (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .run      (wdt_enable && lf_on && core_reset_n),
    .tick     (lf_tick),
    .load     (wdt_clear || !core_reset_n),
    .load_val (wdt_reload),
    .count    (),
    .expire   (wdt_expire)
  );

  always_comb begin
    next_wdt_irq = wdt_expire && wdt_interval_mode;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_irq <= 1'b0;
    end else begin
      wdt_irq <= next_wdt_irq;
    end
  end

endmodule

//--- tb/psrc_core_model.sv
// Core side model: loads the sleep interval, then waits for interrupt
module psrc_core_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Bench request
  input  wire logic        sleep_go,
  input  wire logic [31:0] interval_in,
  // Controller side
  input  wire logic        core_run,
  output logic             wait_for_interrupt_instr,
  output logic [31:0]      sleep_interval
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  step;
  logic [1:0]  next_step;
  logic        next_wfi;
  logic [31:0] next_interval;
  always_comb begin
    next_step = step;
    next_wfi = 1'b0;
    next_interval = sleep_interval;
    case (step)
      2'h0: if (sleep_go) begin
        next_interval = interval_in;
        next_step = 2'h1;
      end
      // Interval settles a cycle before the wait instruction
      2'h1: if (core_run) begin
        next_wfi = 1'b1;
        next_step = 2'h2;
      end
      default: if (!sleep_go) next_step = 2'h0;
    endcase
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      step <= 2'h0;
      wait_for_interrupt_instr <= 1'b0;
      sleep_interval <= 32'h0;
    end else begin
      step <= next_step;
      wait_for_interrupt_instr <= next_wfi;
      sleep_interval <= next_interval;
    end
  end
endmodule

//--- tb/psrc_top_assertions.sv
// Port checker for the power-state and reset controller
module psrc_chk
  import psrc_pkg::*;
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  arst_n,
  // Causes and core
  input wire logic                  ext_reset_pin_n,
  input wire logic                  por_n,
  input wire logic                  brownout,
  input wire logic                  wait_for_interrupt_instr,
  input wire logic                  deep_sleep_sel,
  input wire logic                  core_reset_n,
  input wire logic                  core_run,
  input wire logic                  core_clk_en,
  input wire logic                  wake_irq,
  input wire psrc_state_t           power_state,
  // Wake lines and supplies
  input wire logic [WAKE_LINES-1:0] wake_port0_lines,
  input wire logic [WAKE_LINES-1:0] wake_port1_lines,
  input wire logic [WAKE_LINES-1:0] wake_port0_en,
  input wire logic [WAKE_LINES-1:0] wake_port1_en,
  input wire logic                  lf_xtal_en,
  input wire logic                  lf_rc_en,
  input wire logic                  sleep_timer_en,
  input wire logic                  dig_reg_en,
  input wire logic                  hf_xtal_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       hit;
  logic       calm;
  logic [4:0] wake_run;
  // Counter stands in for a long repetition of the wake state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_run <= 5'h00;
    end else if (power_state == ST_WAKE) begin
      wake_run <= wake_run + 5'h01;
    end else begin
      wake_run <= 5'h00;
    end
  end
  assign hit = |(wake_port0_lines & wake_port0_en) |
               |(wake_port1_lines & wake_port1_en);
  assign calm = ext_reset_pin_n && por_n && !brownout;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_CLK_GATE: assert property (wait_for_interrupt_instr && core_run
    |-> !core_clk_en) else $error("clock not gated on wait");
  AST_SLEEP_IN: assert property (wait_for_interrupt_instr && core_run
    && calm && !deep_sleep_sel |=> power_state == ST_SLEEP)
    else $error("sleep not entered");
  AST_DEEP_STAY: assert property (power_state == ST_DEEP && !hit
    && calm |=> power_state == ST_DEEP) else $error("deep sleep left");
  AST_WAKE_LEN: assert property ($rose(power_state == ST_WAKE)
    |-> ##15 (power_state == ST_WAKE && wake_run == 5'h0f) ##1
    (power_state == ST_ACTIVE && wake_irq && wake_run == 5'h10))
    else $error("wake length wrong");
  AST_WAKE_CLK: assert property (power_state == ST_WAKE
    |-> core_clk_en && dig_reg_en) else $error("wake without clock");
  AST_DEEP_PWR: assert property (power_state == ST_DEEP |-> !dig_reg_en
    && !lf_xtal_en && !lf_rc_en && !sleep_timer_en)
    else $error("deep sleep supply on");
  AST_SLEEP_PWR: assert property (power_state == ST_SLEEP
    |-> !dig_reg_en && sleep_timer_en && (lf_xtal_en || lf_rc_en))
    else $error("sleep supplies wrong");
  AST_IDLE_PWR: assert property (power_state == ST_IDLE
    |-> dig_reg_en && hf_xtal_en && sleep_timer_en)
    else $error("idle supplies wrong");
  AST_LF_ONE: assert property (!(lf_xtal_en && lf_rc_en))
    else $error("both slow oscillators on");
  AST_PIN_RST: assert property (!ext_reset_pin_n ##1
    !ext_reset_pin_n |-> !core_reset_n && power_state == ST_ACTIVE
    && dig_reg_en) else $error("pin reset not held");
endmodule

bind psrc_top psrc_chk chk_u (.mclk, .arst_n, .ext_reset_pin_n, .por_n,
  .brownout, .wait_for_interrupt_instr, .deep_sleep_sel, .core_reset_n,
  .core_run, .core_clk_en, .wake_irq, .power_state, .wake_port0_lines,
  .wake_port1_lines, .wake_port0_en, .wake_port1_en, .lf_xtal_en, .lf_rc_en,
  .sleep_timer_en, .dig_reg_en, .hf_xtal_en);

//--- tb/testbench.sv
// Self-checking bench for the power-state and reset controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import psrc_pkg::*;
  logic mclk, arst_n, ext_reset_pin_n, por_n, brownout, deep_sleep_sel;
  logic idle_req, radio_req, sleep_go, lf_tick, lf_rc_sel, wdt_enable;
  logic wdt_interval_mode, wdt_clear, hf_xtal_is_16m, wait_for_interrupt_instr;
  logic core_reset_n, core_run, core_clk_en, wake_irq, wake_by_timer, wdt_irq;
  logic lf_xtal_en, lf_rc_en, sleep_timer_en, dig_reg_en, hf_xtal_en;
  logic hf_doubler_en, sys_clk_div_tick;
  logic [31:0] interval_in, sleep_interval;
  logic [15:0] wdt_reload;
  logic [7:0]  wake_port0_lines, wake_port1_lines;
  logic [7:0]  wake_port0_en, wake_port1_en;
  logic [3:0]  rst_cause;
  logic [1:0]  sys_clk_div_sel;
  psrc_state_t power_state;
  int          n_fail, checks_done, cycles, n_irq, n_div;

  psrc_top dut_u (.mclk, .arst_n, .ext_reset_pin_n, .por_n, .brownout,
    .wait_for_interrupt_instr, .deep_sleep_sel, .idle_req, .radio_req,
    .core_reset_n, .core_run, .core_clk_en, .wake_irq, .wake_by_timer,
    .rst_cause, .power_state, .wake_port0_lines, .wake_port1_lines,
    .wake_port0_en, .wake_port1_en, .lf_tick, .lf_rc_sel, .lf_xtal_en,
    .lf_rc_en, .sleep_interval, .sleep_timer_en, .wdt_enable,
    .wdt_interval_mode, .wdt_clear, .wdt_reload, .wdt_irq, .hf_xtal_is_16m,
    .sys_clk_div_sel, .dig_reg_en, .hf_xtal_en, .hf_doubler_en,
    .sys_clk_div_tick);
  psrc_core_model core_u (.mclk, .arst_n, .sleep_go, .interval_in,
    .core_run, .wait_for_interrupt_instr, .sleep_interval);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sample a little after the edge so its updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk) lf_tick <= 1'b1;
      @(posedge mclk) lf_tick <= 1'b0;
      cyc(4);
    end
  endtask
  task automatic go_sleep(input logic deep, input logic [31:0] iv);
    @(posedge mclk);
    deep_sleep_sel <= deep;
    interval_in <= iv;
    sleep_go <= 1'b1;
    for (int i = 0; i < 20 && power_state == ST_ACTIVE; i++) cyc(1);
    @(posedge mclk) sleep_go <= 1'b0;
    cyc(1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power;
    int n;
    chk("core_reset_n", core_reset_n, 1);
    chk("rst_cause", rst_cause, 0);
    chk("lf_xtal_en", lf_xtal_en, 1);
    @(posedge mclk);
    idle_req <= 1'b1;
    lf_rc_sel <= 1'b1;
    hf_xtal_is_16m <= 1'b1;
    cyc(4);
    chk("idle", power_state, ST_IDLE);
    chk("lf_rc", {lf_rc_en, lf_xtal_en}, 2'h2);
    chk("doubler", hf_doubler_en, 1);
    @(posedge mclk) radio_req <= 1'b1;
    cyc(3);
    chk("radio", power_state, ST_RADIO);
    @(posedge mclk);
    idle_req <= 1'b0;
    radio_req <= 1'b0;
    lf_rc_sel <= 1'b0;
    cyc(3);
    chk("active", power_state, ST_ACTIVE);
    @(posedge mclk) sys_clk_div_sel <= 2'h2;
    cyc(2);
    n = n_div;
    cyc(16);
    chk("div_ticks", n_div - n, 4);
    $display("power states done");
  endtask
  task automatic t_timer;
    int n;
    go_sleep(1'b0, 32'h3);
    chk("sleep", power_state, ST_SLEEP);
    chk("sleep_pwr", {dig_reg_en, sleep_timer_en}, 2'h1);
    n = 0;
    while (n < 6 && power_state == ST_SLEEP) begin
      tick(1);
      n++;
    end
    chk("ticks", n, 3);
    for (int i = 0; i < 30 && wake_irq !== 1'b1; i++) cyc(1);
    chk("wake_irq", wake_irq, 1);
    chk("by_timer", wake_by_timer, 1);
    $display("timer wake done");
  endtask
  task automatic t_deep;
    int n;
    go_sleep(1'b1, 32'h1);
    chk("deep", power_state, ST_DEEP);
    chk("dpwr", {dig_reg_en, lf_xtal_en, lf_rc_en, sleep_timer_en}, 0);
    tick(3);
    chk("no_timer", power_state, ST_DEEP);
    @(posedge mclk);
    wake_port0_en <= 8'hfe;
    wake_port0_lines <= 8'h01;
    cyc(5);
    chk("masked", power_state, ST_DEEP);
    @(posedge mclk);
    wake_port1_en <= 8'h80;
    wake_port1_lines <= 8'h80;
    n = 0;
    while (n < 40 && wake_irq !== 1'b1) begin
      cyc(1);
      n++;
    end
    chk("wake_len", n, 17);
    chk("by_ext", wake_by_timer, 0);
    @(posedge mclk);
    wake_port0_lines <= 8'h00;
    wake_port1_lines <= 8'h00;
    $display("deep wake done");
  endtask
  task automatic t_causes;
    int n;
    for (int c = 0; c < 3; c++) begin
      @(posedge mclk);
      ext_reset_pin_n <= (c != 0);
      por_n <= (c != 1);
      brownout <= (c == 2);
      cyc(4);
      chk("held", {core_reset_n, dig_reg_en, power_state}, 5'h08);
      @(posedge mclk);
      ext_reset_pin_n <= 1'b1;
      por_n <= 1'b1;
      brownout <= 1'b0;
      n = 0;
      while (n < 300 && core_reset_n !== 1'b1) begin
        cyc(1);
        n++;
      end
      chk("hold", n >= RST_HOLD_CYC, 1);
      chk("cause", rst_cause, 32'h1 << c);
    end
    $display("reset causes done");
  endtask
  task automatic t_wdt;
    int n;
    @(posedge mclk) wdt_enable <= 1'b1;
    n = 0;
    while (n < 8 && core_reset_n === 1'b1) begin
      tick(1);
      n++;
    end
    chk("wdt_ticks", n, 2);
    @(posedge mclk) wdt_enable <= 1'b0;
    for (int i = 0; i < 300 && core_reset_n !== 1'b1; i++) cyc(1);
    chk("wdt_cause", rst_cause, 4'h8);
    @(posedge mclk) begin
      wdt_interval_mode <= 1'b1;
      wdt_enable <= 1'b1;
    end
    n = n_irq;
    tick(4);
    chk("wdt_irqs", n_irq - n, 2);
    chk("no_bite", core_reset_n, 1);
    $display("watchdog done");
  endtask

  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Whole run needs about 700 cycles
  always @(posedge mclk) begin
    cycles++;
    if (wdt_irq === 1'b1) n_irq++;
    if (sys_clk_div_tick === 1'b1) n_div++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {arst_n, brownout, deep_sleep_sel, idle_req, radio_req, sleep_go} = '0;
    {lf_tick, lf_rc_sel, wdt_enable, wdt_interval_mode, wdt_clear} = '0;
    {ext_reset_pin_n, por_n, hf_xtal_is_16m} = 3'h6;
    interval_in = 32'h0;
    wdt_reload = 16'h2;
    {wake_port0_lines, wake_port1_lines, wake_port1_en} = '0;
    wake_port0_en = 8'hff;
    sys_clk_div_sel = 2'h0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    cyc(3);
    t_power;
    t_timer;
    t_deep;
    t_causes;
    t_wdt;
    summarize();
  end
endmodule
